// >>> src/ufip_core.sv
// Function
// R1: serializer out, deserializer in
// R2: programmable baud generator up to 3Mbps; DIV_MIN of 1 allows up to 5Mbps at 8x
// R3: rx, tx, modem, error sources, each maskable
// R4: one interrupt when any unmasked source set
// R5: 8x8 tx fifo, 8x12 rx fifo
// R6: merged 16x8 tx-only fifo mode
// R7: programmable depth, one-deep holding mode
// R8: quarter, half, three-quarter fill thresholds
// R9: send break, detect received break
// R10: five to eight data bits
// R11: even, odd, stick or no parity
// R12: one or two stop bits
// R13: rx time-out, modem change, error interrupts
// R14: fifo level and end-of-transmission interrupts
// R15: rx dma single when data, burst at level
// R16: tx dma single when space, burst at level
// R17: cts pauses tx, rts withheld when full
// R18: standard and low-power infrared encode/decode
// R19: low start, lsb first, idle high
// R20: break is low across a whole frame
`timescale 1ns/10ps
`default_nettype none
module ufip_core (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire ufip_pkg::ufip_cfg_t i_cfg,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_rx_valid,
   output var ufip_pkg::ufip_rx_word_t o_rx_word,
   input wire logic i_rx_ready,
   input wire ufip_pkg::ufip_irq_t i_irq_mask,
   input wire ufip_pkg::ufip_irq_t i_irq_clear,
   output var ufip_pkg::ufip_irq_t o_irq_status,
   output logic o_irq,
   output var ufip_pkg::ufip_dma_t o_dma,
   input wire logic i_rxd,
   input wire logic i_cts_n,
   output logic o_txd,
   output logic o_rts_n,
   output logic o_tx_busy
);
   // ********
   // block state
   // ********
   typedef struct packed {
      logic [ufip_pkg::DIV_W-1:0] baud_cnt; // tick divider
      logic tick; // oversample tick
      logic [2:0] rx_sync; // rx pin synchroniser
      logic rx_f; // filtered rx level
      logic [2:0] cts_sync; // cts pin synchroniser
      logic cts_f; // filtered cts_n level
      logic cts_prev; // for change detect
      ufip_pkg::ufip_ser_t tx_st;
      logic [3:0] tx_sub; // tick within bit
      logic [2:0] tx_bit; // data bit index
      logic [7:0] tx_sh; // outgoing shifter
      logic tx_par;
      logic tx_stop2; // second stop pending
      logic [6:0] tx_cyc; // clocks within bit
      logic txd;
      ufip_pkg::ufip_ser_t rx_st;
      logic [3:0] rx_sub;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh; // incoming shifter
      logic rx_par; // sampled parity bit
      logic rx_brkwait; // line still low after break
      logic oe_pend; // overrun tag for next word
      logic [3:0] ir_cnt; // infrared pulse stretcher
      logic [9:0] rto; // idle tick count
      logic eot_prev;
      logic rts_n;
      ufip_pkg::ufip_irq_t irq; // sticky sources
   } ufip_core_t;

   ufip_core_t st;
   ufip_core_t nx;

   // ********
   // derived terms
   // ********
   logic [ufip_pkg::DIV_W-1:0] div_eff; // divisor, clamped
   logic [3:0] os_last; // last tick index
   logic [3:0] os_mid; // mid-bit tick index
   logic [2:0] wlast; // last data bit index
   logic [ufip_pkg::CNT_W-1:0] tx_lim;
   logic [ufip_pkg::CNT_W-1:0] rx_lim;
   logic [ufip_pkg::CNT_W-1:0] tx_thr;
   logic [ufip_pkg::CNT_W-1:0] rx_thr;
   logic [ufip_pkg::CNT_W-1:0] tx_cnt;
   logic [ufip_pkg::CNT_W-1:0] rx_cnt;
   logic [9:0] rto_lim;
   logic tx_valid_f; // tx fifo has a byte
   logic [7:0] tx_head; // tx fifo head byte
   logic tx_pop; // take head byte
   logic rx_push; // store received word
   logic rx_ready_f; // rx fifo has room
   logic rx_pop;
   logic [ufip_pkg::RX_W-1:0] rx_head; // rx fifo head
   ufip_pkg::ufip_rx_word_t rx_word; // word being stored
   ufip_pkg::ufip_irq_t set; // events this cycle
   logic tx_end; // last tick of tx bit
   logic rx_mid; // mid-bit sample
   logic rx_end; // full bit after mid
   logic rx_in; // decoded rx level
   logic tx_bitval; // line value of current bit
   logic ir_pulse; // infrared pulse window
   logic rx_go; // receiver allowed

   // R2: divisor clamped to DIV_MIN, which rounds down to 1 clock per tick
   assign div_eff = (i_cfg.div < ufip_pkg::DIV_MIN) ? ufip_pkg::DIV_MIN : i_cfg.div;
   assign os_last = i_cfg.os8 ? ufip_pkg::OS8_LAST : ufip_pkg::OS16_LAST;
   assign os_mid = i_cfg.os8 ? ufip_pkg::OS8_MID : ufip_pkg::OS16_MID;
   // R10: word length sets last bit
   assign wlast = {1'b0, i_cfg.wlen} + ufip_pkg::WBIT_BASE;
   // R7: capacity follows fifo mode
   assign tx_lim = ufip_pkg::fifo_lim(i_cfg, 1'b1);
   assign rx_lim = ufip_pkg::fifo_lim(i_cfg, 1'b0);
   // R8: selectable fill thresholds
   assign tx_thr = ufip_pkg::lvl_thr(tx_lim, i_cfg.tx_lvl);
   assign rx_thr = ufip_pkg::lvl_thr(rx_lim, i_cfg.rx_lvl);
   assign rto_lim = i_cfg.os8 ? ufip_pkg::RTO8 : ufip_pkg::RTO16;
   assign tx_end = st.tick && (st.tx_sub == os_last);
   assign rx_mid = st.tick && (st.rx_sub == os_mid);
   assign rx_end = st.tick && (st.rx_sub == os_last);
   // R6: merged mode is output only
   assign rx_go = i_cfg.enable && !i_cfg.fifo_comb;
   assign rx_pop = o_rx_valid && i_rx_ready;
   assign o_rx_word = ufip_pkg::ufip_rx_word_t'(rx_head);

   // R18: stretched pulse decodes as low bit
   assign rx_in = i_cfg.irda_en ? (st.rx_f && (st.ir_cnt == '0)) : st.rx_f;

   // R19: start low, data lsb first, stop high
   assign tx_bitval = (st.tx_st == ufip_pkg::SER_START) ? 1'b0 :
                      (st.tx_st == ufip_pkg::SER_DATA) ? st.tx_sh[0] :
                      (st.tx_st == ufip_pkg::SER_PAR) ? st.tx_par : 1'b1;

   // R18: pulse width, 3 ticks (3/16 bit at 16x, 3/8 at 8x) or fixed short
   assign ir_pulse = i_cfg.irda_lp ? (st.tx_cyc < ufip_pkg::IR_LP_CYC) :
                     (st.tx_sub < ufip_pkg::IR_STD_TICKS);

   // ********
   // fifos
   // ********
   // R5: transmit store, R6 merged capacity
   ufip_fifo #(.W(ufip_pkg::TX_W), .D(ufip_pkg::TX_DEPTH)) u_tx_fifo (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_lim(tx_lim),
      .i_push_valid(i_tx_valid),
      .i_push_data(i_tx_data),
      .o_push_ready(o_tx_ready),
      .o_pop_valid(tx_valid_f),
      .o_pop_data(tx_head),
      .i_pop_ready(tx_pop),
      .o_count(tx_cnt)
   );

   // R5: receive store with status bits
   ufip_fifo #(.W(ufip_pkg::RX_W), .D(ufip_pkg::RX_DEPTH)) u_rx_fifo (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_lim(rx_lim),
      .i_push_valid(rx_push),
      .i_push_data(rx_word),
      .o_push_ready(rx_ready_f),
      .o_pop_valid(o_rx_valid),
      .o_pop_data(rx_head),
      .i_pop_ready(rx_pop),
      .o_count(rx_cnt)
   );

   // ********
   // next state
   // ********
   always_comb begin
      nx = st;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_word = '0;
      set = '0;
      // R2: oversample tick from divider
      if (st.baud_cnt == '0) begin
         nx.baud_cnt = div_eff - 1'b1;
         nx.tick = i_cfg.enable;
      end else begin
         nx.baud_cnt = st.baud_cnt - 1'b1;
         nx.tick = 1'b0;
      end
      // pin synchronisers, change once stages 2 and 3 agree
      nx.rx_sync = {st.rx_sync[1:0], i_rxd};
      nx.cts_sync = {st.cts_sync[1:0], i_cts_n};
      if (st.rx_sync[1] == st.rx_sync[2]) begin
         nx.rx_f = st.rx_sync[2];
      end
      if (st.cts_sync[1] == st.cts_sync[2]) begin
         nx.cts_f = st.cts_sync[2];
      end
      nx.cts_prev = st.cts_f;
      // R13: modem status change
      set.modem = st.cts_f ^ st.cts_prev;
      // R18: infrared stretcher, reloaded while pulse low
      if (!st.rx_f) begin
         nx.ir_cnt = os_last;
      end else if (st.tick && (st.ir_cnt != '0)) begin
         nx.ir_cnt = st.ir_cnt - 1'b1;
      end

      // ********
      // transmitter
      // ********
      if (st.tick) begin
         nx.tx_sub = tx_end ? '0 : st.tx_sub + 1'b1;
      end
      if (tx_end) begin
         nx.tx_cyc = '0;
      end else if (st.tx_cyc != '1) begin
         nx.tx_cyc = st.tx_cyc + 1'b1;
      end
      unique case (st.tx_st)
         ufip_pkg::SER_IDLE: begin
            // R17: hold off while cts withheld
            if (tx_valid_f && i_cfg.enable && !i_cfg.send_brk &&
                !(i_cfg.flow_en && st.cts_f)) begin
               tx_pop = 1'b1;
               nx.tx_sh = tx_head;
               // R11: parity generated at load
               nx.tx_par = ufip_pkg::par_bit(tx_head, i_cfg.wlen, i_cfg.par);
               nx.tx_st = ufip_pkg::SER_START;
               nx.tx_sub = '0;
               nx.tx_cyc = '0;
            end
         end
         ufip_pkg::SER_START: begin
            if (tx_end) begin
               nx.tx_st = ufip_pkg::SER_DATA;
               nx.tx_bit = '0;
            end
         end
         ufip_pkg::SER_DATA: begin
            // R1: shift out lsb first
            if (tx_end) begin
               nx.tx_sh = st.tx_sh >> 1;
               nx.tx_bit = st.tx_bit + 1'b1;
               // R10: stop after chosen length
               if (st.tx_bit == wlast) begin
                  nx.tx_st = (i_cfg.par == ufip_pkg::PAR_NONE) ?
                             ufip_pkg::SER_STOP : ufip_pkg::SER_PAR;
                  // R12: second stop bit
                  nx.tx_stop2 = i_cfg.two_stop;
               end
            end
         end
         ufip_pkg::SER_PAR: begin
            if (tx_end) begin
               nx.tx_st = ufip_pkg::SER_STOP;
            end
         end
         ufip_pkg::SER_STOP: begin
            // R12: one or two stop periods
            if (tx_end) begin
               if (st.tx_stop2) begin
                  nx.tx_stop2 = 1'b0;
               end else begin
                  nx.tx_st = ufip_pkg::SER_IDLE;
               end
            end
         end
      endcase
      // R9: break forces line low
      nx.txd = !i_cfg.send_brk &&
               (i_cfg.irda_en ? (tx_bitval || !ir_pulse) : tx_bitval);

      // ********
      // receiver
      // ********
      if (st.tick) begin
         nx.rx_sub = rx_end ? '0 : st.rx_sub + 1'b1;
      end
      unique case (st.rx_st)
         ufip_pkg::SER_IDLE: begin
            nx.rx_sub = '0;
            // R9: wait for line release after break
            if (st.rx_brkwait) begin
               nx.rx_brkwait = !rx_in;
            end else if (rx_go && !rx_in) begin
               nx.rx_st = ufip_pkg::SER_START;
               nx.rx_par = 1'b0;
            end
         end
         ufip_pkg::SER_START: begin
            // R19: start must still be low mid-bit
            if (rx_mid) begin
               nx.rx_sub = '0;
               nx.rx_bit = '0;
               nx.rx_st = rx_in ? ufip_pkg::SER_IDLE : ufip_pkg::SER_DATA;
            end
         end
         ufip_pkg::SER_DATA: begin
            // R1: assemble bits lsb first
            if (rx_end) begin
               nx.rx_sh = {rx_in, st.rx_sh[7:1]};
               nx.rx_bit = st.rx_bit + 1'b1;
               if (st.rx_bit == wlast) begin
                  nx.rx_st = (i_cfg.par == ufip_pkg::PAR_NONE) ?
                             ufip_pkg::SER_STOP : ufip_pkg::SER_PAR;
               end
            end
         end
         ufip_pkg::SER_PAR: begin
            if (rx_end) begin
               nx.rx_par = rx_in;
               nx.rx_st = ufip_pkg::SER_STOP;
            end
         end
         ufip_pkg::SER_STOP: begin
            if (rx_end) begin
               nx.rx_st = ufip_pkg::SER_IDLE;
               rx_word.data = st.rx_sh >> (ufip_pkg::WLEN_MAX - i_cfg.wlen);
               // R20: per-character error flags
               rx_word.frm = !rx_in;
               // R11: parity check
               rx_word.par = (i_cfg.par != ufip_pkg::PAR_NONE) &&
                  (st.rx_par != ufip_pkg::par_bit(rx_word.data, i_cfg.wlen, i_cfg.par));
               // R20: all low through stop is a break
               rx_word.brk = !rx_in && (rx_word.data == '0) && !st.rx_par;
               rx_word.ovr = st.oe_pend;
               rx_push = 1'b1;
               nx.rx_brkwait = rx_word.brk;
               set.frame = rx_word.frm;
               set.parity = rx_word.par;
               set.brk = rx_word.brk;
               // R20: full fifo drops word, tags next
               if (rx_ready_f) begin
                  nx.oe_pend = 1'b0;
               end else begin
                  nx.oe_pend = 1'b1;
                  set.overrun = 1'b1;
               end
            end
         end
      endcase

      // ********
      // events
      // ********
      // R13: time-out after idle with data waiting
      if ((rx_cnt == '0) || rx_push || rx_pop) begin
         nx.rto = '0;
      end else if (st.tick && (st.rto != rto_lim)) begin
         nx.rto = st.rto + 1'b1;
      end
      set.rx_to = (st.rto == rto_lim);
      // R14: fifo level events
      set.rx_lvl = (rx_cnt >= rx_thr);
      set.tx_lvl = (tx_cnt <= tx_thr);
      // R14: end of transmission on going idle
      nx.eot_prev = (st.tx_st == ufip_pkg::SER_IDLE) && (tx_cnt == '0);
      set.eot = nx.eot_prev && !st.eot_prev;
      // R3: sticky, set wins over clear
      nx.irq = ufip_pkg::ufip_irq_t'((st.irq & ~i_irq_clear) | set);
      // R17: withhold rts when rx store full
      nx.rts_n = i_cfg.flow_en ? (rx_cnt >= rx_lim) : 1'b0;
   end

   // ********
   // state register
   // ********
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st <= '0;
         st.rx_sync <= '1;
         st.rx_f <= 1'b1;
         st.cts_sync <= '1;
         st.cts_f <= 1'b1;
         st.cts_prev <= 1'b1;
         st.txd <= 1'b1;
         st.eot_prev <= 1'b1;
         st.rts_n <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   // ********
   // outputs
   // ********
   assign o_txd = st.txd;
   assign o_rts_n = st.rts_n;
   assign o_irq_status = st.irq;
   assign o_tx_busy = st.tx_st != ufip_pkg::SER_IDLE;
   // R4: one combined interrupt
   assign o_irq = |(st.irq & i_irq_mask);
   // R15: receive dma requests
   assign o_dma.rx_single = rx_cnt != '0;
   assign o_dma.rx_burst = rx_cnt >= rx_thr;
   // R16: transmit dma requests
   assign o_dma.tx_single = o_tx_ready;
   assign o_dma.tx_burst = tx_cnt <= tx_thr;
endmodule : ufip_core
`default_nettype wire

// >>> src/ufip_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ufip_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [ufip_pkg::CNT_W-1:0] i_lim,
   input wire logic i_push_valid,
   input wire logic [W-1:0] i_push_data,
   output logic o_push_ready,
   output logic o_pop_valid,
   output logic [W-1:0] o_pop_data,
   input wire logic i_pop_ready,
   output logic [ufip_pkg::CNT_W-1:0] o_count
);
   localparam int AW = $clog2(D);

   // ********
   // storage state
   // ********
   typedef struct packed {
      logic [D-1:0][W-1:0] mem; // entry array
      logic [AW-1:0] wp; // write pointer
      logic [AW-1:0] rp; // read pointer
      logic [ufip_pkg::CNT_W-1:0] cnt; // fill level
   } ufip_fifo_t;

   ufip_fifo_t st_reg;
   ufip_fifo_t st_next;
   logic push;
   logic pop;

   // full at the programmed capacity, not the store size
   assign o_push_ready = st_reg.cnt < i_lim;
   assign o_pop_valid = st_reg.cnt != '0;
   assign o_pop_data = st_reg.mem[st_reg.rp];
   assign o_count = st_reg.cnt;
   assign push = i_push_valid && o_push_ready;
   assign pop = o_pop_valid && i_pop_ready;

   // next pointers and level
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wp] = i_push_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : ufip_fifo
`default_nettype wire

// >>> src/ufip_pkg.sv
package ufip_pkg;
   // ********
   // sizes and codes
   // ********
   localparam int TX_DEPTH = 16; // tx store, holds merged capacity
   localparam int RX_DEPTH = 8;
   localparam int TX_W = 8;
   localparam int RX_W = 12;
   localparam int CNT_W = 5;
   localparam int DIV_W = 16;
   localparam logic [CNT_W-1:0] LIM_ONE = 5'h01; // holding-register mode
   localparam logic [CNT_W-1:0] LIM_STD = 5'h08;
   localparam logic [CNT_W-1:0] LIM_COMB = 5'h10; // merged tx fifo
   localparam logic [3:0] OS16_LAST = 4'hf; // last tick of a bit, 16x
   localparam logic [3:0] OS8_LAST = 4'h7;
   localparam logic [3:0] OS16_MID = 4'h7; // mid-bit sample point
   localparam logic [3:0] OS8_MID = 4'h3;
   localparam logic [3:0] IR_STD_TICKS = 4'h3; // 3-tick pulse, 3/16 bit at 16x, 3/8 bit at 8x
   localparam logic [2:0] WBIT_BASE = 3'h4; // index of bit 5
   localparam logic [1:0] WLEN_MAX = 2'h3;
   localparam logic [7:0] BYTE_MASK = 8'hff;

   // ********
   // timing
   // ********
   localparam int CLK_HZ = 40_000_000;
   localparam int CLK_NS = 25;
   localparam int BAUD_MAX_BPS = 3_000_000;
   localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / (8 * BAUD_MAX_BPS));
   localparam int IR_LP_NS = 1630; // low-power pulse width
   localparam logic [6:0] IR_LP_CYC = 7'((IR_LP_NS + CLK_NS - 1) / CLK_NS);
   localparam int RTO_BITS = 32; // idle bit times before time-out
   localparam logic [9:0] RTO16 = 10'(RTO_BITS * 16);
   localparam logic [9:0] RTO8 = 10'(RTO_BITS * 8);

   // ********
   // types
   // ********
   typedef enum logic [2:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_STICK1, PAR_STICK0} ufip_par_t;
   typedef enum logic [1:0] {LVL_QUARTER, LVL_HALF, LVL_3QUARTER} ufip_lvl_t;
   typedef enum logic [2:0] {SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP} ufip_ser_t;

   typedef struct packed {
      logic enable; // unit on
      logic os8; // 8x oversampling, else 16x
      logic [DIV_W-1:0] div; // core clocks per oversample tick
      logic [1:0] wlen; // 0..3 = 5..8 data bits
      ufip_par_t par;
      logic two_stop;
      logic fifo_en; // 0 = one-deep holding register
      logic fifo_comb; // merge into 16-deep tx fifo
      logic flow_en; // rts/cts handshake
      logic irda_en;
      logic irda_lp; // low-power pulse width
      ufip_lvl_t tx_lvl;
      ufip_lvl_t rx_lvl;
      logic send_brk;
   } ufip_cfg_t;

   typedef struct packed {
      logic rx_lvl;
      logic tx_lvl;
      logic rx_to;
      logic modem;
      logic frame;
      logic parity;
      logic brk;
      logic overrun;
      logic eot;
   } ufip_irq_t;

   typedef struct packed {
      logic ovr;
      logic brk;
      logic par;
      logic frm;
      logic [7:0] data;
   } ufip_rx_word_t;

   typedef struct packed {
      logic rx_single;
      logic rx_burst;
      logic tx_single;
      logic tx_burst;
   } ufip_dma_t;

   // ********
   // helpers
   // ********
   // usable capacity of a fifo under the current mode
   function automatic logic [CNT_W-1:0] fifo_lim(input ufip_cfg_t c, input logic is_tx);
      fifo_lim = !c.fifo_en ? LIM_ONE : (c.fifo_comb && is_tx) ? LIM_COMB : LIM_STD;
   endfunction : fifo_lim

   // fill threshold, never below one entry
   function automatic logic [CNT_W-1:0] lvl_thr(input logic [CNT_W-1:0] lim,
                                                input ufip_lvl_t l);
      logic [CNT_W-1:0] t;
      case (l)
         LVL_QUARTER: t = lim >> 2;
         LVL_HALF: t = lim >> 1;
         default: t = (lim >> 1) + (lim >> 2);
      endcase
      lvl_thr = (t == '0) ? LIM_ONE : t;
   endfunction : lvl_thr

   // parity over the active data bits
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wlen,
                                    input ufip_par_t m);
      logic [7:0] v;
      v = d & (BYTE_MASK >> (WLEN_MAX - wlen));
      case (m)
         PAR_EVEN: par_bit = ^v;
         PAR_ODD: par_bit = ~^v;
         PAR_STICK1: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction : par_bit
endpackage : ufip_pkg

// >>> tb/tb_ufip_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ufip_core;
   localparam int BIT = 16;
   logic i_core_clk = 1'h0, i_resetn = 1'h0, i_tx_valid = 1'h0, i_rx_ready = 1'h1;
   logic stall = 1'h0, g, o_tx_ready, o_rx_valid, o_irq, o_txd, o_rts_n, o_tx_busy;
   logic i_rxd, i_cts_n, got;
   logic [7:0] i_tx_data = 8'h00, d;
   logic [3:0] nb = 4'h9;
   logic [9:0] bits, f;
   ufip_pkg::ufip_cfg_t i_cfg = '0;
   ufip_pkg::ufip_irq_t i_irq_mask = '1, i_irq_clear = '0, o_irq_status;
   ufip_pkg::ufip_rx_word_t o_rx_word;
   ufip_pkg::ufip_dma_t o_dma;
   logic [11:0] exp_rx[$], exp_tx[$];
   int fail_count = 0, checks_done = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   ufip_core ufip_core_inst (.i_core_clk, .i_resetn, .i_cfg, .i_tx_valid, .i_tx_data,
      .o_tx_ready, .o_rx_valid, .o_rx_word, .i_rx_ready, .i_irq_mask, .i_irq_clear,
      .o_irq_status, .o_irq, .o_dma, .i_rxd, .i_cts_n, .o_txd, .o_rts_n, .o_tx_busy);
   ufip_remote #(.BIT(BIT)) ufip_remote_inst (.i_core_clk, .i_txd(o_txd), .i_stall(stall),
      .i_nb(nb), .o_rxd(i_rxd), .o_cts_n(i_cts_n), .o_got(got), .o_bits(bits));
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : cyc
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic push(input logic [7:0] v, input logic [9:0] e);
      exp_tx.push_back({2'h0, e});
      i_tx_valid = 1'h1;
      i_tx_data = v;
      do @(posedge i_core_clk); while (!o_tx_ready);
      #1 i_tx_valid = 1'h0;
   endtask : push
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // bits after the start: data, parity, stop
   function automatic logic [9:0] fbits(input logic [7:0] v, input int w, input int k);
      logic [9:0] r;
      r = {2'h0, v & (8'hff >> (3 - w))};
      if (k != 0) r[w + 5] = (k == 1) ? ^r : (k == 2) ? ~^r : (k == 3);
      r[w + 5 + (k != 0)] = 1'h1;
      return r;
   endfunction : fbits
   // results against the oldest note
   always @(negedge i_core_clk) begin
      if (i_resetn && o_rx_valid && i_rx_ready) chk("rx word", exp_rx.pop_front(), o_rx_word);
      if (got) chk("tx frame", exp_tx.pop_front(), {2'h0, bits});
   end
   initial begin
      void'($urandom(99552));
      i_cfg.enable = 1'h1;
      i_cfg.div = 16'h0001;
      i_cfg.fifo_en = 1'h1;
      i_cfg.rx_lvl = ufip_pkg::LVL_HALF;
      cyc(4);
      chk("reset pins", 12'h1c3, {3'h0, o_txd, o_rts_n, o_tx_ready, o_rx_valid, o_tx_busy, o_dma});
      chk("reset irq", 12'h000, 12'(o_irq_status));
      i_resetn = 1'h1;
      cyc(2);
      for (int w = 0; w < 4; w++) begin
         for (int k = 0; k < 5; k++) begin
            d = 8'($urandom);
            g = (k != 0) && d[1];
            i_cfg.wlen = 2'(w);
            i_cfg.par = ufip_pkg::ufip_par_t'(k);
            i_cfg.two_stop = d[0];
            f = fbits(d, w, k);
            nb = 4'(w + 6 + (k != 0));
            exp_rx.push_back({2'h0, g, 1'h0, d & (8'hff >> (3 - w))});
            push(d, f);
            ufip_remote_inst.send({f ^ (10'(g) << (w + 5)), 1'h0}, nb + 1);
            cyc(3 * BIT);
         end
      end
      i_cfg.par = ufip_pkg::PAR_NONE;
      i_cfg.two_stop = 1'h0;
      nb = 4'h9;
      exp_rx.push_back(12'h500);
      ufip_remote_inst.send(12'h800, 12);
      cyc(BIT);
      chk("brk flag", 12'h001, 12'(o_irq_status.brk));
      exp_tx.push_back(12'h000);
      i_cfg.send_brk = 1'h1;
      cyc(12 * BIT);
      chk("brk line", 12'h000, 12'(o_txd));
      i_cfg.send_brk = 1'h0;
      cyc(3 * BIT);
      i_cfg.flow_en = 1'h1;
      for (int fe = 1; fe >= 0; fe--) begin
         i_cfg.fifo_en = 1'(fe);
         i_rx_ready = 1'h0;
         i_irq_mask = ufip_pkg::ufip_irq_t'($urandom);
         for (int n = 0; n <= (fe ? 8 : 1); n++) begin
            d = 8'($urandom);
            if (n < (fe ? 8 : 1)) exp_rx.push_back({!fe, 3'h0, d}); // ovr tags word after drop
            ufip_remote_inst.send({2'h1, d, 1'h0}, 10);
         end
         cyc(600);
         chk("full", 12'h00f, {8'h00, o_irq_status.overrun, o_irq_status.rx_to,
            o_irq_status.rx_lvl, o_rts_n});
         i_rx_ready = 1'h1;
         i_irq_clear = '1;
         cyc(12);
         i_irq_clear = '0;
         cyc(1);
         chk("drained", 12'h000, {10'h000, o_rx_valid, o_irq_status.overrun});
      end
      i_cfg.fifo_en = 1'h1;
      i_irq_mask = '1;
      stall = 1'h1;
      cyc(10);
      d = 8'($urandom);
      push(d, {2'h1, d});
      cyc(40);
      chk("paused", 12'h001, {9'h000, o_tx_busy, o_rts_n, o_irq_status.modem});
      stall = 1'h0;
      cyc(14 * BIT);
      chk("eot", 12'h001, 12'(o_irq_status.eot));
      chk("queues", 12'h000, 12'(exp_rx.size() + exp_tx.size()));
      print_verdict();
   end
   initial begin
      cyc(30000);
      fail_count++;
      print_verdict();
   end
endmodule : tb_ufip_core
`default_nettype wire

// >>> tb/ufip_remote.sv
`timescale 1ns/10ps
`default_nettype none
module ufip_remote #(
   parameter int BIT = 16
) (
   input wire logic i_core_clk,
   input wire logic i_txd,
   input wire logic i_stall,
   input wire logic [3:0] i_nb,
   output logic o_rxd,
   output logic o_cts_n,
   output logic o_got,
   output logic [9:0] o_bits
);
   assign o_cts_n = i_stall;
   initial begin
      o_rxd = 1'h1;
      o_got = 1'h0;
      o_bits = '0;
   end
   // start low, lsb first, idle high
   // last bit stays on the line, so frames end high
   task automatic send(input logic [11:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         o_rxd <= fr[i];
         repeat (BIT) @(posedge i_core_clk);
      end
   endtask : send
   // sample mid-bit after the start edge
   always begin
      @(negedge i_txd);
      o_bits <= '0;
      repeat (BIT / 2) @(posedge i_core_clk);
      for (int i = 0; i < i_nb; i++) begin
         repeat (BIT) @(posedge i_core_clk);
         o_bits[i] <= i_txd;
      end
      o_got <= 1'h1;
      @(posedge i_core_clk);
      o_got <= 1'h0;
   end
endmodule : ufip_remote
`default_nettype wire

// >>> tb/ufip_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ufip_sva (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire ufip_pkg::ufip_cfg_t i_cfg,
   input wire logic i_rx_ready,
   input wire ufip_pkg::ufip_irq_t i_irq_mask,
   input wire logic i_cts_n,
   input wire logic o_tx_ready,
   input wire logic o_rx_valid,
   input wire ufip_pkg::ufip_rx_word_t o_rx_word,
   input wire ufip_pkg::ufip_irq_t o_irq_status,
   input wire logic o_irq,
   input wire ufip_pkg::ufip_dma_t o_dma,
   input wire logic o_txd,
   input wire logic o_rts_n,
   input wire logic o_tx_busy
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // idle while the far side withholds clear-to-send
   sequence s_held;
      (i_cfg.flow_en && i_cts_n && !o_tx_busy) [*6];
   endsequence
   a_irq_merge: assert property (o_irq == |(o_irq_status & i_irq_mask))
      else $error("irq not merged status");
   a_rx_single: assert property (o_dma.rx_single == o_rx_valid)
      else $error("rx single request wrong");
   a_tx_single: assert property (o_dma.tx_single == o_tx_ready)
      else $error("tx single request wrong");
   a_brk_drive: assert property (i_cfg.send_brk |=> !o_txd)
      else $error("break not driven");
   a_idle_high: assert property (!o_tx_busy && !i_cfg.send_brk && !$past(i_cfg.send_brk) |-> o_txd)
      else $error("idle line not high");
   a_cts_hold: assert property (s_held |=> !o_tx_busy)
      else $error("sent without clear");
   a_rts_free: assert property (!i_cfg.flow_en |=> !o_rts_n)
      else $error("rts held without flow");
   a_word_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
      else $error("rx head changed");
   a_brk_word: assert property (o_rx_valid && o_rx_word.brk |-> o_rx_word.frm && !(|o_rx_word.data))
      else $error("break word malformed");
endmodule : ufip_sva
bind ufip_core ufip_sva ufip_sva_inst (.i_core_clk, .i_resetn, .i_cfg, .i_rx_ready, .i_irq_mask,
   .i_cts_n, .o_tx_ready, .o_rx_valid, .o_rx_word, .o_irq_status, .o_irq, .o_dma, .o_txd,
   .o_rts_n, .o_tx_busy);
`default_nettype wire
